// File: hdl/loudness_regs.svh
// Register offsets, field positions, reset values and timing counts of the loudness meter
`ifndef LOUDNESS_REGS_SVH
`define LOUDNESS_REGS_SVH
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0C
`define OFS_COUNT 8'h10
`define CTRL_REMOTE_EN_BIT 0
`define CTRL_RESET 1'b1
`define IRQ_MASK_RESET 3'h0
`define IRQ_MODE_BIT 0
`define IRQ_LEVEL_BIT 1
`define IRQ_TRIP_BIT 2
`define STAT_MODE_LSB 0
`define STAT_TRIP_BIT 2
`define STAT_RUN_BIT 3
`define STAT_LEVEL_LSB 8
`define CLK_MHZ 200
`define SAMPLE_PERIOD_MS 850
`define SAMPLE_CYCLES (`SAMPLE_PERIOD_MS * `CLK_MHZ * 1000)
`define DEBOUNCE_MS 5
`define DEBOUNCE_CYCLES (`DEBOUNCE_MS * `CLK_MHZ * 1000)
`define REF_LEVEL_DB 85
`define TRIP_BASE_DB 78
`define TRIP_OFF_SEL 4'hF
`endif

// File: hdl/loudness_pkg.sv
// Types shared by the loudness meter
package loudness_pkg;
   typedef enum logic [1:0] {
      MODE_CAL = 2'h0,
      MODE_MEAS = 2'h1,
      MODE_STOP = 2'h3
   } mode_t;
   typedef enum logic [1:0] {
      CALC_IDLE = 2'h0,
      CALC_DIV = 2'h1,
      CALC_LOG = 2'h3
   } calc_t;
   // Front buttons and remote contact, 1 = pressed or closed
   typedef struct packed {
      logic cal;
      logic start;
      logic stop;
      logic remote_closed;
   } panel_t;
endpackage : loudness_pkg

// File: hdl/loudness_meter.sv
// Loudness meter mode control, long-term averaging and APB register file
//
// Contract
// - Contact close or stop: stop, flash level (the code stops only from measurement; in calibration both are ignored)
// - Contact open or start: new measurement
// - Calibrate button always enters calibration
// - Remote start from calibration needs close-open
// - 12-bit level sample taken for averaging
// - Sample every 850 ms, sum, divide
// - Square root, dB, reference reads 85
// - Stop clears sum and averager, holds display
// - Three-state mode, button LEDs, change interrupt
// - One remote line acts as start/stop
// - Logic signal runs the analog averager
// - Trip checked only at stop
// - Selector 0..E is 78..92, F disables
//
// Our own choices: register access over APB and the placing of the registers.
`include "loudness_regs.svh"
module loudness_meter import loudness_pkg::*; #(
   parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES,
   parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
   parameter logic [11:0] REF_CODE = 12'h400,
   parameter int CNT_W = 20
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire panel_t panel_i,
   input wire logic [3:0] trip_sel_i,
   input wire logic [11:0] adc_sample_i,
   output logic adc_take_o,
   output logic [7:0] level_o,
   output logic display_flash_o,
   output logic led_cal_o,
   output logic led_run_o,
   output logic led_stop_o,
   output logic avg_run_o,
   output logic trip_o,
   output logic trip_led_o,
   output logic irq_o
);
   localparam int TW = $clog2(SAMPLE_CYCLES);
   localparam int DW = $clog2(DEBOUNCE_CYCLES) + 1;
   localparam int SW = 12 + CNT_W;
   localparam int BW = $clog2(SW);

   // Input conditioning
   logic [3:0] s1_ff, s2_ff, db_ff, dbp_ff, nxt_db;
   logic [3:0][DW-1:0] dcnt_ff, nxt_dcnt;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         nxt_db[i] = db_ff[i];
         nxt_dcnt[i] = '0;
         if (s2_ff[i] != db_ff[i]) begin
            // Level must hold for the whole window before it is believed
            if (dcnt_ff[i] == DW'(DEBOUNCE_CYCLES - 1)) begin
               nxt_db[i] = s2_ff[i];
            end else begin
               nxt_dcnt[i] = dcnt_ff[i] + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_ff <= 4'h0;
         s2_ff <= 4'h0;
         db_ff <= 4'h0;
         dbp_ff <= 4'h0;
         dcnt_ff <= '0;
      end else begin
         s1_ff <= panel_i;
         s2_ff <= s1_ff;
         db_ff <= nxt_db;
         dbp_ff <= db_ff;
         dcnt_ff <= nxt_dcnt;
      end
   end

   logic ctrl_ff;
   logic cal_rise, start_rise, stop_rise, rem_close, rem_open, start_ev, stop_ev;
   assign cal_rise = db_ff[3] & ~dbp_ff[3];
   assign start_rise = db_ff[2] & ~dbp_ff[2];
   assign stop_rise = db_ff[1] & ~dbp_ff[1];
   // Edges only, so a line that was already open never starts a run
   assign rem_close = ctrl_ff & db_ff[0] & ~dbp_ff[0];
   assign rem_open = ctrl_ff & ~db_ff[0] & dbp_ff[0];
   assign start_ev = start_rise | rem_open;
   assign stop_ev = stop_rise | rem_close;

   function automatic logic [7:0] log2q(input logic [11:0] m);
      logic [3:0] p;
      logic [11:0] nm;
      p = 4'h0;
      for (int i = 0; i < 12; i++) begin
         if (m[i]) begin
            p = 4'(i);
         end
      end
      nm = m << (4'hB - p);
      return {p, nm[10:7]};
   endfunction : log2q

   // Square root is half the log; 6.02 dB per octave is 96/256 per 1/16 step
   function automatic logic [7:0] to_db(input logic [11:0] m);
      logic signed [9:0] half;
      logic signed [17:0] db;
      half = (signed'({2'h0, log2q(m)}) - signed'({2'h0, log2q(REF_CODE)})) >>> 1;
      db = half * 10'sh060;
      db = ((db + 18'sh00080) >>> 8) + signed'(18'(`REF_LEVEL_DB));
      if (m == 12'h000 || db < 18'sh00000) begin
         return 8'h00;
      end else if (db > 18'sh000FF) begin
         return 8'hFF;
      end
      return db[7:0];
   endfunction : to_db

   // Mode, averaging and trip
   mode_t mode_ff, nxt_mode;
   calc_t calc_ff, nxt_calc;
   logic [TW-1:0] tick_ff, nxt_tick;
   logic [SW-1:0] sum_ff, nxt_sum, quo_ff, nxt_quo, rem_ff, nxt_rem, dvs_ff, nxt_dvs, shv;
   logic [CNT_W-1:0] n_ff, nxt_n;
   logic [BW-1:0] step_ff, nxt_step;
   logic [7:0] level_ff, nxt_level;
   logic trip_ff, nxt_trip, take_ff, nxt_take;
   logic tick, go_meas, mode_chg, ev_level, ev_trip;

   assign tick = tick_ff == TW'(SAMPLE_CYCLES - 1);
   assign go_meas = start_ev & ~cal_rise & ~(stop_ev & (mode_ff == MODE_MEAS));
   assign mode_chg = nxt_mode != mode_ff;

   always_comb begin
      nxt_mode = mode_ff;
      nxt_calc = calc_ff;
      nxt_tick = tick ? '0 : tick_ff + 1'b1;
      nxt_sum = sum_ff;
      nxt_n = n_ff;
      nxt_quo = quo_ff;
      nxt_rem = rem_ff;
      nxt_dvs = dvs_ff;
      nxt_step = step_ff;
      nxt_level = level_ff;
      nxt_trip = trip_ff;
      nxt_take = 1'b0;
      ev_level = 1'b0;
      ev_trip = 1'b0;
      shv = {rem_ff[SW-2:0], quo_ff[SW-1]};
      if (cal_rise) begin
         nxt_mode = MODE_CAL;
      end else if (stop_ev && mode_ff == MODE_MEAS) begin
         nxt_mode = MODE_STOP;
      end else if (go_meas) begin
         nxt_mode = MODE_MEAS;
      end
      if (mode_ff != MODE_STOP && tick) begin
         nxt_take = 1'b1;
         if (mode_ff == MODE_CAL) begin
            // Calibration shows the latest sample alone
            nxt_sum = SW'(adc_sample_i);
            nxt_n = CNT_W'(1);
         end else begin
            nxt_sum = sum_ff + SW'(adc_sample_i);
            nxt_n = n_ff + 1'b1;
         end
         nxt_quo = nxt_sum;
         nxt_dvs = SW'(nxt_n);
         nxt_rem = '0;
         nxt_step = '0;
         nxt_calc = CALC_DIV;
      end else begin
         case (calc_ff)
            CALC_IDLE: begin
               nxt_calc = CALC_IDLE;
            end
            CALC_DIV: begin
               // One quotient bit a cycle: sum over elapsed periods
               if (shv >= dvs_ff) begin
                  nxt_rem = shv - dvs_ff;
                  nxt_quo = {quo_ff[SW-2:0], 1'b1};
               end else begin
                  nxt_rem = shv;
                  nxt_quo = {quo_ff[SW-2:0], 1'b0};
               end
               nxt_step = step_ff + 1'b1;
               if (step_ff == BW'(SW - 1)) begin
                  nxt_calc = CALC_LOG;
               end
            end
            CALC_LOG: begin
               nxt_level = to_db((|quo_ff[SW-1:12]) ? 12'hFFF : quo_ff[11:0]);
               ev_level = 1'b1;
               nxt_calc = CALC_IDLE;
            end
            default: begin
               nxt_calc = CALC_IDLE;
            end
         endcase
      end
      if (go_meas || nxt_mode != mode_ff) begin
         // Both the new run and the stop start from an empty average
         nxt_tick = '0;
         nxt_sum = '0;
         nxt_n = '0;
      end
      if (mode_ff == MODE_MEAS && nxt_mode == MODE_STOP) begin
         // Judged on the final level only
         nxt_trip = (trip_sel_i != `TRIP_OFF_SEL) && (level_ff > 8'(`TRIP_BASE_DB) + 8'(trip_sel_i));
         ev_trip = nxt_trip;
      end else if (nxt_mode != MODE_STOP) begin
         nxt_trip = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_ff <= MODE_STOP;
         calc_ff <= CALC_IDLE;
         tick_ff <= '0;
         sum_ff <= '0;
         n_ff <= '0;
         quo_ff <= '0;
         rem_ff <= '0;
         dvs_ff <= '0;
         step_ff <= '0;
         level_ff <= 8'h00;
         trip_ff <= 1'b0;
         take_ff <= 1'b0;
         led_cal_o <= 1'b0;
         led_run_o <= 1'b0;
         led_stop_o <= 1'b1;
         display_flash_o <= 1'b1;
         avg_run_o <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         calc_ff <= nxt_calc;
         tick_ff <= nxt_tick;
         sum_ff <= nxt_sum;
         n_ff <= nxt_n;
         quo_ff <= nxt_quo;
         rem_ff <= nxt_rem;
         dvs_ff <= nxt_dvs;
         step_ff <= nxt_step;
         level_ff <= nxt_level;
         trip_ff <= nxt_trip;
         take_ff <= nxt_take;
         led_cal_o <= nxt_mode == MODE_CAL;
         led_run_o <= nxt_mode == MODE_MEAS;
         led_stop_o <= nxt_mode == MODE_STOP;
         display_flash_o <= nxt_mode == MODE_STOP;
         avg_run_o <= nxt_mode == MODE_MEAS;
      end
   end

   assign adc_take_o = take_ff;
   assign level_o = level_ff;
   assign trip_o = trip_ff;
   assign trip_led_o = trip_ff;

   // APB slave: one wait state, then the access completes
   logic [2:0] mask_ff, nxt_mask, irq_ff, nxt_irq, rd_clr;
   logic [31:0] nxt_prdata;
   logic nxt_pready, nxt_slverr, nxt_ctrl, commit;

   assign commit = psel_i & penable_i & pready_o;

   always_comb begin
      nxt_pready = psel_i & penable_i & ~pready_o;
      nxt_prdata = prdata_o;
      nxt_slverr = pslverr_o;
      nxt_ctrl = ctrl_ff;
      nxt_mask = mask_ff;
      rd_clr = 3'h0;
      if (nxt_pready) begin
         nxt_prdata = 32'h0000_0000;
         nxt_slverr = 1'b0;
         case (paddr_i)
            `OFS_CTRL: nxt_prdata[`CTRL_REMOTE_EN_BIT] = ctrl_ff;
            `OFS_STATUS: begin
               nxt_prdata[`STAT_MODE_LSB +: 2] = mode_ff;
               nxt_prdata[`STAT_TRIP_BIT] = trip_ff;
               nxt_prdata[`STAT_RUN_BIT] = avg_run_o;
               nxt_prdata[`STAT_LEVEL_LSB +: 8] = level_ff;
            end
            `OFS_IRQ_STAT: nxt_prdata[2:0] = irq_ff;
            `OFS_IRQ_MASK: nxt_prdata[2:0] = mask_ff;
            `OFS_COUNT: nxt_prdata[CNT_W-1:0] = n_ff;
            default: nxt_slverr = 1'b1;
         endcase
      end
      if (commit && pwrite_i && paddr_i == `OFS_CTRL) begin
         nxt_ctrl = pwdata_i[`CTRL_REMOTE_EN_BIT];
      end
      if (commit && pwrite_i && paddr_i == `OFS_IRQ_MASK) begin
         nxt_mask = pwdata_i[2:0];
      end
      // Clear only what the read reported; a new event wins over the clear
      if (commit && !pwrite_i && paddr_i == `OFS_IRQ_STAT) begin
         rd_clr = prdata_o[2:0];
      end
      nxt_irq = (irq_ff & ~rd_clr) | {ev_trip, ev_level, mode_chg};
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
         ctrl_ff <= `CTRL_RESET;
         mask_ff <= `IRQ_MASK_RESET;
         irq_ff <= 3'h0;
         irq_o <= 1'b0;
      end else begin
         pready_o <= nxt_pready;
         prdata_o <= nxt_prdata;
         pslverr_o <= nxt_slverr;
         ctrl_ff <= nxt_ctrl;
         mask_ff <= nxt_mask;
         irq_ff <= nxt_irq;
         irq_o <= |(nxt_irq & nxt_mask);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_cal_wins;
      cal_rise |=> mode_ff == MODE_CAL && led_cal_o;
   endproperty
   a_cal_wins: assert property (p_cal_wins) else $error("calibrate press not obeyed");

   property p_stop;
      stop_ev && !cal_rise && mode_ff == MODE_MEAS |=> mode_ff == MODE_STOP && display_flash_o && !avg_run_o;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not end measurement");

   property p_start;
      go_meas |=> mode_ff == MODE_MEAS && n_ff == '0 && sum_ff == '0 ##1 tick_ff == TW'(1);
   endproperty
   a_start: assert property (p_start) else $error("start did not open a fresh run");

   property p_cal_hold;
      mode_ff == MODE_CAL && !start_rise && !rem_open |=> mode_ff == MODE_CAL;
   endproperty
   a_cal_hold: assert property (p_cal_hold) else $error("calibration left without open edge");

   property p_accum;
      tick && mode_ff == MODE_MEAS && !mode_chg && !go_meas |=>
         n_ff == $past(n_ff) + 1'b1 && sum_ff == $past(sum_ff) + SW'($past(adc_sample_i)) && adc_take_o;
   endproperty
   a_accum: assert property (p_accum) else $error("sample not accumulated");

   property p_calc_time;
      calc_ff == CALC_DIV && step_ff == '0 |-> ##(SW + 1) calc_ff == CALC_IDLE && $past(calc_ff) == CALC_LOG;
   endproperty
   a_calc_time: assert property (p_calc_time) else $error("level update late or early");

   property p_stop_clear;
      mode_ff == MODE_MEAS && nxt_mode == MODE_STOP |=> sum_ff == '0 && n_ff == '0 && !avg_run_o;
   endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("average not reset at stop");

   property p_mode_irq;
      $changed(mode_ff) |-> irq_ff[`IRQ_MODE_BIT] ##1 (irq_o || !mask_ff[`IRQ_MODE_BIT] || !irq_ff[0]);
   endproperty
   a_mode_irq: assert property (p_mode_irq) else $error("mode change raised no interrupt");

   property p_run_line;
      avg_run_o == (mode_ff == MODE_MEAS) && led_run_o == avg_run_o;
   endproperty
   a_run_line: assert property (p_run_line) else $error("averager run line wrong");

   property p_no_trip_run;
      mode_ff == MODE_MEAS |-> !trip_o && !trip_led_o;
   endproperty
   a_no_trip_run: assert property (p_no_trip_run) else $error("trip during measurement");

   property p_trip_off;
      mode_ff == MODE_MEAS && nxt_mode == MODE_STOP && trip_sel_i == `TRIP_OFF_SEL |=> !trip_o;
   endproperty
   a_trip_off: assert property (p_trip_off) else $error("trip with selector off");

   c_run_stop: cover property (mode_ff == MODE_MEAS ##1 mode_ff == MODE_STOP);
   c_remote_start: cover property (mode_ff == MODE_CAL && rem_open ##1 mode_ff == MODE_MEAS);
   c_trip: cover property ($rose(trip_o));
   c_level: cover property (ev_level && mode_ff == MODE_MEAS);
endmodule : loudness_meter

// File: bench/contact_model.sv
// Remote start-stop contact that chatters on every change
module contact_model (
   input wire logic clk_i,
   input wire logic close_i,
   output logic contact_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic settled = 1'b0;
   logic line_ff = 1'b0;
   int chatter = 0;
   assign contact_o = line_ff;
   // A relay bounces before it settles, so the block must filter it
   always @(posedge clk_i) begin
      if (close_i !== settled) begin
         settled <= close_i;
         chatter <= 3;
      end
      if (chatter > 0) begin
         chatter <= chatter - 1;
         line_ff <= ~line_ff;
      end else begin
         line_ff <= settled;
      end
   end
endmodule : contact_model

// File: bench/tb_top.sv
// Self-checking bench of the loudness meter mode control and averaging
`include "loudness_regs.svh"
module tb_top import loudness_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SAMP = 200;
   localparam int DEB = 4;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, close_cmd = 1'b0, contact;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [2:0] btn = 3'h0;
   logic [3:0] trip_sel = 4'h0;
   logic [11:0] adc = 12'h400;
   logic pready, pslverr, take, flash, led_cal, led_run, led_stop, avg_run, trip, trip_led, irq;
   logic [7:0] level;
   logic [64:0] exp_q[$];
   logic [64:0] exp_e;
   logic [31:0] seed = 32'h00012EAD;
   logic [3:0] sel;
   int n_fail = 0, cmp_count = 0, cycles = 0, n_take = 0;
   panel_t panel;
   assign panel = {btn, contact};
   always #2.5 clk_i = ~clk_i;
   contact_model remote_u (.clk_i(clk_i), .close_i(close_cmd), .contact_o(contact));
   loudness_meter #(.SAMPLE_CYCLES(SAMP), .DEBOUNCE_CYCLES(DEB)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .panel_i(panel), .trip_sel_i(trip_sel),
      .adc_sample_i(adc), .adc_take_o(take), .level_o(level), .display_flash_o(flash), .led_cal_o(led_cal),
      .led_run_o(led_run), .led_stop_o(led_stop), .avg_run_o(avg_run), .trip_o(trip), .trip_led_o(trip_led),
      .irq_o(irq));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   always @(posedge clk_i) begin
      cycles++;
      if (take === 1'b1) n_take++;
      if (cycles == 30000) begin
         n_fail++;
         end_of_test();
      end
   end
   // Read data judged against the oldest note, at the edge the master samples it
   always @(posedge clk_i) begin
      if (psel && penable && pready === 1'b1) begin
         exp_e = exp_q.pop_front();
         check({31'h0, pslverr}, {31'h0, exp_e[64]});
         check(prdata & exp_e[63:32], exp_e[31:0] & exp_e[63:32]);
      end
   end
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic e);
      int n;
      n = 0;
      exp_q.push_back({e, m, d});
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n == 20) check(32'h0, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      apb(1'b0, a, d, m, 1'b0);
   endtask : rd
   task automatic chk_mode(input mode_t m);
      logic [4:0] e;
      e = (m == MODE_CAL) ? 5'h10 : (m == MODE_MEAS) ? 5'h0A : 5'h05;
      check({27'h0, led_cal, led_run, led_stop, avg_run, flash}, {27'h0, e});
      rd(`OFS_STATUS, {30'h0, m}, 32'h3);
   endtask : chk_mode
   task automatic press(input int b);
      btn[b] <= 1'b1;
      repeat (DEB + 8) @(posedge clk_i);
      btn[b] <= 1'b0;
      repeat (DEB + 8) @(posedge clk_i);
   endtask : press
   task automatic remote(input logic v);
      close_cmd <= v;
      repeat (DEB + 14) @(posedge clk_i);
   endtask : remote
   // One measurement from stop to stop with a constant level code
   task automatic run(input logic [11:0] s, input logic [3:0] ts, input logic [7:0] lv);
      int n, base;
      adc <= s;
      trip_sel <= ts;
      base = n_take;
      press(1);
      chk_mode(MODE_MEAS);
      n = 0;
      while (level !== lv && n < 1200) begin
         @(posedge clk_i);
         n++;
      end
      check({24'h0, level}, {24'h0, lv});
      check({30'h0, trip, trip_led}, 32'h0);
      while (n_take - base < 3 && n < 1800) begin
         @(posedge clk_i);
         n++;
      end
      rd(`OFS_COUNT, 32'h3, 32'h000FFFFF);
      press(0);
      chk_mode(MODE_STOP);
      check({24'h0, level}, {24'h0, lv});
      rd(`OFS_STATUS, {16'h0, lv, 8'h0}, 32'h0000FF00);
      check({30'h0, trip, trip_led}, {30'h0, {2{ts != 4'hF && lv > 8'h4E + ts}}});
      base = n_take;
      repeat (SAMP + 20) @(posedge clk_i);
      check(n_take - base, 32'h0);
   endtask : run
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      chk_mode(MODE_STOP);
      check({24'h0, level}, 32'h0);
      rd(`OFS_IRQ_MASK, 32'h0, 32'hFFFFFFFF);
      rd(`OFS_CTRL, 32'h1, 32'hFFFFFFFF);
      apb(1'b0, 8'h14, 32'h0, 32'hFFFFFFFF, 1'b1);
      // Bounce-length tap on start must not change mode
      btn[1] <= 1'b1;
      repeat (2) @(posedge clk_i);
      btn[1] <= 1'b0;
      repeat (20) @(posedge clk_i);
      chk_mode(MODE_STOP);
      for (int i = 0; i < 3; i++) begin
         sel = (i == 2) ? 4'hF : 4'(rnd());
         run(12'h400, sel, 8'h55);
      end
      run(12'h100, 4'h0, 8'h4F);
      apb(1'b1, `OFS_IRQ_MASK, 32'h1, 32'h0, 1'b0);
      repeat (2) @(posedge clk_i);
      check({31'h0, irq}, 32'h1);
      rd(`OFS_IRQ_STAT, 32'h7, 32'h7);
      repeat (2) @(posedge clk_i);
      check({31'h0, irq}, 32'h0);
      rd(`OFS_IRQ_STAT, 32'h0, 32'h7);
      sel = 4'(rnd()) & 4'h7;
      apb(1'b1, `OFS_IRQ_MASK, {28'h0, sel}, 32'h0, 1'b0);
      rd(`OFS_IRQ_MASK, {28'h0, sel}, 32'hFFFFFFFF);
      adc <= 12'h400;
      press(1);
      remote(1'b1);
      chk_mode(MODE_STOP);
      check({31'h0, avg_run}, 32'h0);
      remote(1'b0);
      chk_mode(MODE_MEAS);
      press(2);
      chk_mode(MODE_CAL);
      repeat (20) @(posedge clk_i);
      chk_mode(MODE_CAL);
      remote(1'b1);
      chk_mode(MODE_CAL);
      remote(1'b0);
      chk_mode(MODE_MEAS);
      press(0);
      // Calibration shows one sample at a quarter of the reference code alone
      adc <= 12'h100;
      press(2);
      chk_mode(MODE_CAL);
      repeat (SAMP + 60) @(posedge clk_i);
      check({24'h0, level}, 32'h4F);
      end_of_test();
   end
endmodule : tb_top
